// ### rtl/desc_pkg.sv
// constants for the enable-usage, stop and output command block
// Behaviour
// - usage 1 means enabled only while enable input reads open (high).
// - usage 2 means enabled only while enable input reads closed (low).
// - usage 3 ignores enable input for enabling; it reads as general input.
// - enable-usage command ignored while a speed-change control mode is active.
// - choosing a speed-change control mode forces enable usage to 3.
// - alarm-clear usage 1 or 2 takes the input and forces enable usage 3.
// - alarm clear, enable usage, speed-change modes never own the input together.
// - variable-I/O units accept point parameter; only points 1 and 3 allowed.
// - chosen point must already be an input before it can serve as enable.
// - standard-I/O units reject the point-selecting parameter.
// - jog halt decelerates a jog using the jog acceleration setting.
// - halt-and-flush stops the running command and erases the command buffer.
// - halt-and-flush without parameter decelerates at max acceleration setting.
// - halt-and-flush with D uses decel setting for feeds, jog accel for jogs.
// - set-output drives the output only when no dedicated function owns it.
// - set-output takes output number 1 and level L or H.
// - a point reads low when current flows, high when no current flows.
package desc_pkg;
  typedef enum logic [2:0]
  {
    DESC_OP_NONE      = 3'b000,
    DESC_OP_EN_USAGE  = 3'b001,
    DESC_OP_JOG_HALT  = 3'b010,
    DESC_OP_HALT_KILL = 3'b011,
    DESC_OP_SET_OUT   = 3'b100,
    DESC_OP_CTRL_MODE = 3'b101,
    DESC_OP_ALARM_USE = 3'b110,
    DESC_OP_IO_DIR    = 3'b111
  } desc_op_t;

  typedef enum logic [1:0]
  {
    DESC_RATE_NONE  = 2'b00,
    DESC_RATE_MAX   = 2'b01,
    DESC_RATE_DECEL = 2'b10,
    DESC_RATE_JOG   = 2'b11
  } desc_rate_t;

  localparam logic [1:0] EN_USE_OPEN   = 2'h1;
  localparam logic [1:0] EN_USE_CLOSED = 2'h2;
  localparam logic [1:0] EN_USE_NONE   = 2'h3;
  localparam logic [1:0] EN_USE_RST    = 2'h3;
  localparam logic [4:0] MODE_SPD_A    = 5'h0D;
  localparam logic [4:0] MODE_SPD_B    = 5'h0E;
  localparam logic [4:0] MODE_SPD_C    = 5'h11;
  localparam logic [4:0] MODE_SPD_D    = 5'h12;
  localparam logic [4:0] MODE_RST      = 5'h07;
  localparam logic [1:0] ALARM_USE_RST = 2'h3;
  localparam logic [2:0] EN_POINT_A    = 3'h1;
  localparam logic [2:0] EN_POINT_B    = 3'h3;
  localparam logic [2:0] EN_POINT_RST  = 3'h3;
  localparam logic [2:0] OUT_NUM       = 3'h1;
  localparam logic [3:0] DIR_RST       = 4'h7;
  localparam int         IO_POINTS     = 4;
endpackage

// ### rtl/desc_in_sync.sv
// two-flop synchroniser for the I/O pin inputs
`timescale 1ns/1ps
`default_nettype none
module desc_in_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;
endmodule
`default_nettype wire

// ### rtl/desc_cmd_ctrl.sv
// command interpreter for enable usage, stop commands and digital output
`timescale 1ns/1ps
`default_nettype none
module desc_cmd_ctrl #(
  parameter bit VAR_IO = 1'b1,
  parameter int NPTS   = desc_pkg::IO_POINTS
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 cmd_valid,
  input  wire desc_pkg::desc_op_t   cmd_op,
  input  wire logic [4:0]           cmd_arg1,
  input  wire logic [2:0]           cmd_arg2,
  input  wire logic                 cmd_has_arg2,
  input  wire logic                 cmd_flag,
  input  wire logic [NPTS-1:0]      io_pin_n,
  input  wire logic                 jog_active,
  input  wire logic                 feed_active,
  input  wire logic                 alarm_output_function,
  input  wire logic                 brake_output_function,
  input  wire logic                 motion_output_function,
  output logic                      cmd_accept,
  output logic                      cmd_reject,
  output logic                      drive_enabled,
  output logic [1:0]                en_usage,
  output logic [2:0]                en_point,
  output logic [1:0]                alarm_clear_input_usage,
  output logic [4:0]                control_mode_setting,
  output logic [NPTS-1:0]           io_is_input,
  output logic [NPTS-1:0]           io_level_high,
  output logic                      motion_stop,
  output logic                      buffer_flush,
  output desc_pkg::desc_rate_t      stop_rate,
  output logic                      out_pin_high
);
  logic [NPTS-1:0]      pins_s;
  logic [1:0]           en_use_q;
  logic [1:0]           en_use_d;
  logic [2:0]           en_pt_q;
  logic [2:0]           en_pt_d;
  logic [1:0]           alarm_q;
  logic [1:0]           alarm_d;
  logic [4:0]           mode_q;
  logic [4:0]           mode_d;
  logic [NPTS-1:0]      dir_q;
  logic [NPTS-1:0]      dir_d;
  logic                 out_q;
  logic                 out_d;
  logic                 acc_q;
  logic                 rej_q;
  logic                 ena_q;
  logic                 stop_q;
  logic                 flush_q;
  desc_pkg::desc_rate_t rate_q;
  desc_pkg::desc_rate_t rate_d;
  logic [NPTS-1:0]      lvl_q;

  function automatic logic is_spd_mode(input logic [4:0] m);
    is_spd_mode = (m == desc_pkg::MODE_SPD_A) || (m == desc_pkg::MODE_SPD_B) ||
                  (m == desc_pkg::MODE_SPD_C) || (m == desc_pkg::MODE_SPD_D);
  endfunction

  function automatic logic is_alarm_use(input logic [1:0] a);
    is_alarm_use = (a == 2'h1) || (a == 2'h2);
  endfunction

  desc_in_sync #(
    .W (NPTS)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   (io_pin_n),
    .pin_sync (pins_s)
  );

  // command classification
  wire op_en   = cmd_valid && (cmd_op == desc_pkg::DESC_OP_EN_USAGE);
  wire op_jog  = cmd_valid && (cmd_op == desc_pkg::DESC_OP_JOG_HALT);
  wire op_kill = cmd_valid && (cmd_op == desc_pkg::DESC_OP_HALT_KILL);
  wire op_out  = cmd_valid && (cmd_op == desc_pkg::DESC_OP_SET_OUT);
  wire op_mode = cmd_valid && (cmd_op == desc_pkg::DESC_OP_CTRL_MODE);
  wire op_alm  = cmd_valid && (cmd_op == desc_pkg::DESC_OP_ALARM_USE);
  wire op_dir  = cmd_valid && (cmd_op == desc_pkg::DESC_OP_IO_DIR);

  wire code_ok  = (cmd_arg1[4:2] == 3'h0) && (cmd_arg1[1:0] != 2'h0);
  wire pt_legal = (cmd_arg2 == desc_pkg::EN_POINT_A) || (cmd_arg2 == desc_pkg::EN_POINT_B);
  wire [1:0] pt_idx = cmd_arg2[1:0] - 2'h1;
  wire pt_is_in = dir_q[pt_idx];
  wire pt_ok    = !cmd_has_arg2 || (VAR_IO && pt_legal && pt_is_in);
  wire en_block = is_spd_mode(mode_q);
  wire en_take  = op_en && code_ok && pt_ok && !en_block;
  wire alm_take = op_alm && (cmd_arg1[4:2] == 3'h0) && (cmd_arg1[1:0] != 2'h0);
  wire out_own  = alarm_output_function || brake_output_function || motion_output_function;
  wire out_num  = (cmd_arg1 == {2'h0, desc_pkg::OUT_NUM});
  wire out_take = op_out && !out_own && out_num;
  wire dir_ok   = (cmd_arg1[4:0] >= 5'h01) && (cmd_arg1[4:0] <= 5'h04);
  wire [1:0] dir_idx = cmd_arg1[1:0] - 2'h1;
  wire take = en_take || op_jog || op_kill || out_take || op_mode || alm_take ||
              (op_dir && dir_ok);
  wire bad  = cmd_valid && !take;

  // drive enable from the selected point; point low means current flows
  wire [1:0] sel_idx = en_pt_q[1:0] - 2'h1;
  wire sel_lvl = VAR_IO ? pins_s[sel_idx] : pins_s[desc_pkg::EN_POINT_B[1:0] - 2'h1];
  wire ena_d = (en_use_q == desc_pkg::EN_USE_OPEN)   ? sel_lvl :
               (en_use_q == desc_pkg::EN_USE_CLOSED) ? !sel_lvl :
               1'b1;

  always_comb
  begin
    en_use_d = en_use_q;
    en_pt_d  = en_pt_q;
    alarm_d  = alarm_q;
    mode_d   = mode_q;
    dir_d    = dir_q;
    out_d    = out_q;
    rate_d   = desc_pkg::DESC_RATE_NONE;
    if (en_take)
    begin
      en_use_d = cmd_arg1[1:0];
      if (cmd_has_arg2)
        en_pt_d = cmd_arg2;
      if (cmd_arg1[1:0] != desc_pkg::EN_USE_NONE)
        alarm_d = desc_pkg::ALARM_USE_RST;
    end
    if (op_mode)
    begin
      mode_d = cmd_arg1;
      if (is_spd_mode(cmd_arg1))
      begin
        en_use_d = desc_pkg::EN_USE_NONE;
        alarm_d  = desc_pkg::ALARM_USE_RST;
      end
    end
    if (alm_take)
    begin
      alarm_d = cmd_arg1[1:0];
      if (is_alarm_use(cmd_arg1[1:0]))
      begin
        en_use_d = desc_pkg::EN_USE_NONE;
        if (is_spd_mode(mode_q))
          mode_d = desc_pkg::MODE_RST;
      end
    end
    if (op_dir && dir_ok)
      dir_d[dir_idx] = cmd_flag;
    if (out_take)
      out_d = cmd_flag;
    if (op_jog && jog_active)
      rate_d = desc_pkg::DESC_RATE_JOG;
    if (op_kill)
    begin
      if (!cmd_flag)
        rate_d = desc_pkg::DESC_RATE_MAX;
      else if (jog_active)
        rate_d = desc_pkg::DESC_RATE_JOG;
      else
        rate_d = desc_pkg::DESC_RATE_DECEL;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      en_use_q <= desc_pkg::EN_USE_RST;
      en_pt_q  <= desc_pkg::EN_POINT_RST;
      alarm_q  <= desc_pkg::ALARM_USE_RST;
      mode_q   <= desc_pkg::MODE_RST;
      dir_q    <= desc_pkg::DIR_RST;
      out_q    <= 1'b1;
    end
    else
    begin
      en_use_q <= en_use_d;
      en_pt_q  <= en_pt_d;
      alarm_q  <= alarm_d;
      mode_q   <= mode_d;
      dir_q    <= dir_d;
      out_q    <= out_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      acc_q   <= 1'b0;
      rej_q   <= 1'b0;
      ena_q   <= 1'b1;
      stop_q  <= 1'b0;
      flush_q <= 1'b0;
      rate_q  <= desc_pkg::DESC_RATE_NONE;
      lvl_q   <= {NPTS{1'b1}};
    end
    else
    begin
      acc_q   <= cmd_valid && take;
      rej_q   <= bad;
      ena_q   <= ena_d;
      stop_q  <= op_kill || (op_jog && jog_active);
      flush_q <= op_kill;
      rate_q  <= rate_d;
      lvl_q   <= pins_s;
    end
  end

  assign cmd_accept              = acc_q;
  assign cmd_reject              = rej_q;
  assign drive_enabled           = ena_q;
  assign en_usage                = en_use_q;
  assign en_point                = en_pt_q;
  assign alarm_clear_input_usage = alarm_q;
  assign control_mode_setting    = mode_q;
  assign io_is_input             = dir_q;
  assign io_level_high           = lvl_q;
  assign motion_stop             = stop_q;
  assign buffer_flush            = flush_q;
  assign stop_rate               = rate_q;
  assign out_pin_high            = out_q;

  // checks
  a_kill_flush_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    op_kill |=> buffer_flush && motion_stop)
    else $error("flush not raised after halt-and-flush");
  a_kill_max_rate: assert property (@(posedge clk) disable iff (sys_rst)
    op_kill && !cmd_flag |=> stop_rate == desc_pkg::DESC_RATE_MAX)
    else $error("plain halt-and-flush not at max rate");
  a_kill_d_rate: assert property (@(posedge clk) disable iff (sys_rst)
    op_kill && cmd_flag |=> stop_rate == (($past(jog_active)) ?
      desc_pkg::DESC_RATE_JOG : desc_pkg::DESC_RATE_DECEL))
    else $error("halt-and-flush D rate wrong");
  a_jog_halt_rate: assert property (@(posedge clk) disable iff (sys_rst)
    op_jog && jog_active && !op_kill
    |=> motion_stop && stop_rate == desc_pkg::DESC_RATE_JOG)
    else $error("jog halt not at jog rate");
  a_spd_blocks_en: assert property (@(posedge clk) disable iff (sys_rst)
    op_en && is_spd_mode(mode_q) |=> $stable(en_usage) && cmd_reject)
    else $error("enable usage changed in speed-change mode");
  a_mode_forces_3: assert property (@(posedge clk) disable iff (sys_rst)
    op_mode && is_spd_mode(cmd_arg1) |=> en_usage == desc_pkg::EN_USE_NONE)
    else $error("speed-change mode did not force usage 3");
  a_alarm_forces_3: assert property (@(posedge clk) disable iff (sys_rst)
    alm_take && is_alarm_use(cmd_arg1[1:0]) |=> en_usage == desc_pkg::EN_USE_NONE)
    else $error("alarm usage did not force usage 3");
  a_single_owner: assert property (@(posedge clk) disable iff (sys_rst)
    !((en_usage != desc_pkg::EN_USE_NONE) && is_alarm_use(alarm_clear_input_usage)) &&
    !((en_usage != desc_pkg::EN_USE_NONE) && is_spd_mode(control_mode_setting)) &&
    !(is_alarm_use(alarm_clear_input_usage) && is_spd_mode(control_mode_setting)))
    else $error("enable input has two owners");
  a_open_enables: assert property (@(posedge clk) disable iff (sys_rst)
    en_use_q == desc_pkg::EN_USE_OPEN && en_pt_q == en_pt_d && $stable(en_use_q)
    |=> drive_enabled == $past(sel_lvl))
    else $error("usage 1 enable level wrong");
  a_closed_enables: assert property (@(posedge clk) disable iff (sys_rst)
    en_use_q == desc_pkg::EN_USE_CLOSED |=> drive_enabled == !$past(sel_lvl))
    else $error("usage 2 enable level wrong");
  a_unused_enables: assert property (@(posedge clk) disable iff (sys_rst)
    en_use_q == desc_pkg::EN_USE_NONE |=> drive_enabled)
    else $error("usage 3 not always enabled");
  a_point_legal: assert property (@(posedge clk) disable iff (sys_rst)
    op_en && cmd_has_arg2 && !(VAR_IO && pt_legal && dir_q[pt_idx])
    |=> cmd_reject && $stable(en_usage) && $stable(en_point))
    else $error("illegal enable point accepted");
  a_out_owned: assert property (@(posedge clk) disable iff (sys_rst)
    op_out && out_own |=> $stable(out_pin_high))
    else $error("owned output was changed");
  a_out_set: assert property (@(posedge clk) disable iff (sys_rst)
    op_out && !out_own && cmd_arg1 == {2'h0, desc_pkg::OUT_NUM}
    |=> out_pin_high == $past(cmd_flag))
    else $error("set-output level wrong");
endmodule
`default_nettype wire

// ### verification/desc_host_model.sv
// host-side model that issues one decoded command at a time
`timescale 1ns/1ps
`default_nettype none
module desc_host_model (
  input  wire logic          clk,
  output logic               cmd_valid,
  output desc_pkg::desc_op_t cmd_op,
  output logic [4:0]         cmd_arg1,
  output logic [2:0]         cmd_arg2,
  output logic               cmd_has_arg2,
  output logic               cmd_flag
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = desc_pkg::DESC_OP_NONE;
    cmd_arg1 = 5'h00;
    cmd_arg2 = 3'h0;
    cmd_has_arg2 = 1'b0;
    cmd_flag = 1'b0;
  end
  // one cycle per command, argument and flag fields scrambled once released, op held
  task automatic send(input desc_pkg::desc_op_t op, input logic [4:0] a1,
                      input logic [2:0] a2, input logic h2, input logic fl);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_arg1 <= a1;
    cmd_arg2 <= a2;
    cmd_has_arg2 <= h2;
    cmd_flag <= fl;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_arg1 <= ~a1;
    cmd_arg2 <= ~a2;
    cmd_has_arg2 <= ~h2;
    cmd_flag <= ~fl;
    #1;
  endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic clk, sys_rst, cmd_valid, cmd_has_arg2, cmd_flag, jog_active, feed_active;
  logic own_a, own_b, own_m, acc, rej, en, stp, fls, outh;
  desc_pkg::desc_op_t   cmd_op;
  desc_pkg::desc_rate_t rate;
  logic [4:0] cmd_arg1, mode;
  logic [2:0] cmd_arg2, pt;
  logic [3:0] pins, isin, lvl;
  logic [1:0] use_q, alu, use_s;
  logic [2:0] r;
  logic       exp_out, ok_o, acc_s, rej_s, en_s;
  int n_mismatch, n_checks, seed;
  localparam logic [4:0] SPD [4] = '{desc_pkg::MODE_SPD_A, desc_pkg::MODE_SPD_B,
                                     desc_pkg::MODE_SPD_C, desc_pkg::MODE_SPD_D};
  desc_host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_arg1(cmd_arg1), .cmd_arg2(cmd_arg2), .cmd_has_arg2(cmd_has_arg2), .cmd_flag(cmd_flag));
  desc_cmd_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_arg1(cmd_arg1), .cmd_arg2(cmd_arg2), .cmd_has_arg2(cmd_has_arg2), .cmd_flag(cmd_flag),
    .io_pin_n(pins), .jog_active(jog_active), .feed_active(feed_active),
    .alarm_output_function(own_a), .brake_output_function(own_b),
    .motion_output_function(own_m), .cmd_accept(acc), .cmd_reject(rej), .drive_enabled(en),
    .en_usage(use_q), .en_point(pt), .alarm_clear_input_usage(alu),
    .control_mode_setting(mode), .io_is_input(isin), .io_level_high(lvl),
    .motion_stop(stp), .buffer_flush(fls), .stop_rate(rate), .out_pin_high(outh));
  desc_cmd_ctrl #(.VAR_IO(1'b0)) i_dut_std (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg1(cmd_arg1), .cmd_arg2(cmd_arg2),
    .cmd_has_arg2(cmd_has_arg2), .cmd_flag(cmd_flag), .io_pin_n(pins),
    .jog_active(jog_active), .feed_active(feed_active), .alarm_output_function(own_a),
    .brake_output_function(own_b), .motion_output_function(own_m), .cmd_accept(acc_s),
    .cmd_reject(rej_s), .drive_enabled(en_s), .en_usage(use_s), .en_point(),
    .alarm_clear_input_usage(), .control_mode_setting(), .io_is_input(), .io_level_high(),
    .motion_stop(), .buffer_flush(), .stop_rate(), .out_pin_high());
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic exp_en(input logic [1:0] code, input logic pin);
    return (code == 2'h1) ? pin : (code == 2'h2) ? ~pin : 1'b1;
  endfunction
  function automatic desc_pkg::desc_rate_t exp_rate(input logic kill, input logic d,
                                                    input logic jog);
    if (!kill) return desc_pkg::DESC_RATE_JOG;
    if (!d) return desc_pkg::DESC_RATE_MAX;
    return jog ? desc_pkg::DESC_RATE_JOG : desc_pkg::DESC_RATE_DECEL;
  endfunction
  task automatic cmd(input desc_pkg::desc_op_t op, input logic [4:0] a1, input logic [2:0] a2,
                     input logic h2, input logic fl, input logic ok);
    i_host.send(op, a1, a2, h2, fl);
    `CHK({acc, rej}, {ok, ~ok})
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    seed = 32'h1F63BBDD;
    {sys_rst, pins, jog_active, feed_active, own_a, own_b, own_m} = {1'b1, 4'hF, 5'h00};
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHK({use_q, pt, alu, mode, isin, outh, en}, {2'h3, 3'h3, 2'h3, 5'h07, 4'h7, 2'h3})
    for (int i = 0; i < 12; i++)
    begin
      cmd(desc_pkg::DESC_OP_EN_USAGE, 5'(1 + i % 3), 3'h3, 1'b1, 1'b0, 1'b1);
      `CHK({acc_s, rej_s, use_s}, {2'h1, 2'h3})
      @(posedge clk);
      pins <= 4'($random(seed));
      repeat (5) @(posedge clk);
      #1;
      `CHK({use_q, pt}, {2'(1 + i % 3), 3'h3})
      `CHK(lvl, pins)
      `CHK(en, exp_en(2'(1 + i % 3), pins[2]))
    end
    $display("test enable usage done");
    cmd(desc_pkg::DESC_OP_EN_USAGE, 5'h1, 3'h2, 1'b1, 1'b0, 1'b0);
    cmd(desc_pkg::DESC_OP_EN_USAGE, 5'h0, 3'h3, 1'b1, 1'b0, 1'b0);
    cmd(desc_pkg::DESC_OP_IO_DIR, 5'h1, 3'h0, 1'b0, 1'b0, 1'b1);
    `CHK(isin, 4'h6)
    cmd(desc_pkg::DESC_OP_EN_USAGE, 5'h1, 3'h1, 1'b1, 1'b0, 1'b0);
    cmd(desc_pkg::DESC_OP_IO_DIR, 5'h1, 3'h0, 1'b0, 1'b1, 1'b1);
    cmd(desc_pkg::DESC_OP_IO_DIR, 5'h5, 3'h0, 1'b0, 1'b1, 1'b0);
    cmd(desc_pkg::DESC_OP_EN_USAGE, 5'h1, 3'h1, 1'b1, 1'b0, 1'b1);
    `CHK({isin, use_q, pt}, {4'h7, 2'h1, 3'h1})
    $display("test point select done");
    cmd(desc_pkg::DESC_OP_EN_USAGE, 5'h2, 3'h0, 1'b0, 1'b0, 1'b1);
    `CHK({acc_s, use_s}, {1'b1, 2'h2})
    @(posedge clk);
    pins <= 4'hB;
    repeat (5) @(posedge clk);
    #1;
    `CHK({en_s, en}, 2'h2)
    $display("test standard io done");
    for (int i = 0; i < 4; i++)
    begin
      cmd(desc_pkg::DESC_OP_EN_USAGE, 5'h1, 3'h3, 1'b1, 1'b0, 1'b1);
      cmd(desc_pkg::DESC_OP_CTRL_MODE, SPD[i], 3'h0, 1'b0, 1'b0, 1'b1);
      `CHK({mode, use_q}, {SPD[i], 2'h3})
      cmd(desc_pkg::DESC_OP_EN_USAGE, 5'h2, 3'h3, 1'b1, 1'b0, 1'b0);
      `CHK(use_q, 2'h3)
      cmd(desc_pkg::DESC_OP_CTRL_MODE, 5'h07, 3'h0, 1'b0, 1'b0, 1'b1);
    end
    cmd(desc_pkg::DESC_OP_EN_USAGE, 5'h1, 3'h3, 1'b1, 1'b0, 1'b1);
    cmd(desc_pkg::DESC_OP_ALARM_USE, 5'h1, 3'h0, 1'b0, 1'b0, 1'b1);
    `CHK({alu, use_q}, {2'h1, 2'h3})
    cmd(desc_pkg::DESC_OP_EN_USAGE, 5'h2, 3'h3, 1'b1, 1'b0, 1'b1);
    `CHK({alu, use_q}, {2'h3, 2'h2})
    cmd(desc_pkg::DESC_OP_ALARM_USE, 5'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    cmd(desc_pkg::DESC_OP_CTRL_MODE, SPD[0], 3'h0, 1'b0, 1'b0, 1'b1);
    cmd(desc_pkg::DESC_OP_ALARM_USE, 5'h2, 3'h0, 1'b0, 1'b0, 1'b1);
    `CHK({alu, use_q, mode}, {2'h2, 2'h3, 5'h07})
    $display("test input ownership done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      jog_active <= i[0];
      cmd(i[2] ? desc_pkg::DESC_OP_HALT_KILL : desc_pkg::DESC_OP_JOG_HALT, 5'h0, 3'h0, 1'b0,
          i[1], 1'b1);
      `CHK({stp, fls}, {i[2] | i[0], i[2]})
      if (i[2] | i[0])
        `CHK(rate, exp_rate(i[2], i[1], i[0]))
      @(posedge clk);
      #1;
      `CHK({stp, fls}, 2'h0)
    end
    $display("test stop commands done");
    exp_out = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      r = 3'($random(seed));
      ok_o = (i % 2 == 0 || r == 3'h0) && i % 5 != 4;
      @(posedge clk);
      {own_a, own_b, own_m} <= (i % 2 == 0) ? 3'h0 : r;
      cmd(desc_pkg::DESC_OP_SET_OUT, (i % 5 == 4) ? 5'(i + 5) : 5'h1, 3'h0, 1'b0, r[0],
          ok_o);
      if (ok_o)
        exp_out = r[0];
      `CHK(outh, exp_out)
    end
    $display("test set output done");
    print_verdict();
  end
endmodule
`default_nettype wire
